// File: hss_pkg.sv
// Shared constants and types for the hot-swap supervisor and its management controller end.
// Assumes a single 40 MHz clock in each end; timer counts derive from it.
`default_nettype none
package hss_pkg;

	localparam int unsigned CLK_FREQ_HZ         = 40_000_000;
	localparam int unsigned CRIT_LOW_TIMEOUT_MS = 10;
	localparam int unsigned RETRY_DELAY_MS      = 1000;
	localparam int unsigned CYCLES_PER_MS       = CLK_FREQ_HZ / 1000;
	localparam int unsigned CRIT_LOW_CYCLES     = CRIT_LOW_TIMEOUT_MS * CYCLES_PER_MS;
	localparam int unsigned RETRY_DELAY_CYCLES  = RETRY_DELAY_MS * CYCLES_PER_MS;

	localparam int unsigned RAMP_RATE_COUNT     = 32;
	localparam int unsigned RAMP_SEL_W          = $clog2(RAMP_RATE_COUNT);
	localparam int unsigned RAMP_UNIT_CYCLES    = 4;
	localparam int unsigned DRIVE_W             = 8;
	localparam logic [7:0]  DRIVE_FULL          = 8'hFF;
	localparam logic [7:0]  DRIVE_ZERO          = 8'h00;

	localparam int unsigned SYNC_IN_W           = 11;

	// Wishbone register map of the controller end
	localparam int unsigned WB_ADR_W            = 4;
	localparam logic [3:0]  REG_CMD_OFS         = 4'h0;
	localparam logic [3:0]  REG_STATUS_OFS      = 4'h4;
	localparam logic [1:0]  CMD_RESET           = 2'h0;
	localparam int unsigned STATUS_RANGE_BIT    = 0;
	localparam int unsigned STATUS_CURRENT_BIT  = 1;
	localparam int unsigned STATUS_FUSE_BIT     = 2;

	typedef enum logic [1:0] {
		CMD_NORMAL     = 2'h0,
		CMD_DEACTIVATE = 2'h1,
		CMD_RETRY      = 2'h2,
		CMD_CTRL_OFF   = 2'h3
	} hss_cmd_t;

endpackage : hss_pkg
`default_nettype wire

// File: hss_link_if.sv
// Opto-isolated link between the hot-swap supervisor and the management controller.
// Assumes both ends sit behind isolators, so every signal is asynchronous to the receiver.
`timescale 1ns/1ps
`default_nettype none
interface hss_link_if;
	logic host_command_bit0;
	logic host_command_bit1;
	logic supply_in_range_ok;
	logic fuses_intact;
	logic current_healthy;

	modport device (
		input  host_command_bit0,
		input  host_command_bit1,
		output supply_in_range_ok,
		output fuses_intact,
		output current_healthy
	);

	modport controller (
		output host_command_bit0,
		output host_command_bit1,
		input  supply_in_range_ok,
		input  fuses_intact,
		input  current_healthy
	);
endinterface : hss_link_if
`default_nettype wire

// File: hss_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous levels; output changes only once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module hss_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] stage2_reg;
	logic [W-1:0] stage3_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg   <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
		end else begin
			meta_reg   <= async_in;
			stage2_reg <= meta_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// A bit follows only when it held the same value over two stable stages
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					sync_out[i] <= 1'b0;
				end else if (stage2_reg[i] == stage3_reg[i]) begin
					sync_out[i] <= stage3_reg[i];
				end
			end
		end
	endgenerate
endmodule : hss_sync
`default_nettype wire

// File: hss_device.sv
// Hot-swap supervisor: pass-switch control, soft start, fault shutdown and status flags.
// Assumes comparator inputs are asynchronous levels, high meaning the named condition is true (volt_low_cmp high: above the low threshold),
// and that the management controller drives the command code over the link.
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R1) Range flag: above low, below high threshold
// (R2) Critical low persisting 10 ms switches off
// (R3) Critical high switches off immediately
// (R4) Low fuse sense means that limb failed
// (R5) Fuse flag only while all fuses intact
// (R6) Current flag high below warning threshold
// (R7) Current trip switches pass switch off
// (R8) Command 00: normal, no action taken
// (R9) Command 01: deactivate, switch stays off
// (R10) Command 10: off, supplies off, 1 s, on
// (R11) Command 11: controller off, secondaries down
// (R12) Soft-start ramp, 32 selectable rates
// (R13) Sequence starts at step 0 on power-up
// (R14) Controller sends two-bit command code
// (R15) Synchronise inputs; clock-derived timer counts
module hss_device
	import hss_pkg::*;
#(
	parameter int unsigned CRIT_LOW_CYCLES_P    = hss_pkg::CRIT_LOW_CYCLES,
	parameter int unsigned RETRY_DELAY_CYCLES_P = hss_pkg::RETRY_DELAY_CYCLES
) (
	input  wire logic                           clk,
	input  wire logic                           arst_n,
	hss_link_if.device                          link,
	input  wire logic                           volt_low_cmp,
	input  wire logic                           volt_high_cmp,
	input  wire logic                           volt_critical_low_cmp,
	input  wire logic                           volt_critical_high_cmp,
	input  wire logic                           current_warn_cmp,
	input  wire logic                           current_trip_cmp,
	input  wire logic                           return_limb_fuse_sense,
	input  wire logic                           neg_limb_fuse_sense,
	input  wire logic                           board_supplies_off,
	input  wire logic [hss_pkg::RAMP_SEL_W-1:0] ramp_rate_sel,
	output var  logic                           pass_switch_drive,
	output var  logic [hss_pkg::DRIVE_W-1:0]    pass_switch_level,
	output var  logic                           fault_shutdown,
	output var  logic                           retry_active
);
	import hss_pkg::*;

	typedef enum logic [2:0] {
		ST_STEP0,
		ST_RAMP,
		ST_ON,
		ST_TRIPPED,
		ST_DEACT,
		ST_RETRY_OFF,
		ST_RETRY_WAIT
	} hss_state_t;

	logic [SYNC_IN_W-1:0] raw_in;
	logic [SYNC_IN_W-1:0] sync_in;
	logic                 low_ok;
	logic                 high_over;
	logic                 crit_low;
	logic                 crit_high;
	logic                 cur_warn;
	logic                 cur_trip;
	logic                 rtn_fuse;
	logic                 neg_fuse;
	logic                 supplies_off;
	hss_cmd_t             cmd;

	hss_state_t           state_reg;
	hss_state_t           state_next;
	hss_cmd_t             cmd_prev_reg;
	logic [31:0]          crit_low_cnt_reg;
	logic                 crit_low_expired;
	logic [31:0]          retry_cnt_reg;
	logic                 retry_done;
	logic                 retry_req;
	logic                 start_ok;
	logic                 run_fault;
	logic                 drive_next;
	logic [15:0]          step_limit;
	logic [15:0]          step_cnt_reg;
	logic                 step_tick;

	assign raw_in = {link.host_command_bit1, link.host_command_bit0, board_supplies_off,
		neg_limb_fuse_sense, return_limb_fuse_sense, current_trip_cmp, current_warn_cmp,
		volt_critical_high_cmp, volt_critical_low_cmp, volt_high_cmp, volt_low_cmp};

	hss_sync #(
		.W        (SYNC_IN_W)
	) i_hss_sync (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in (raw_in),
		.sync_out (sync_in)
	); // R15

	assign low_ok       = sync_in[0];
	assign high_over    = sync_in[1];
	assign crit_low     = sync_in[2];
	assign crit_high    = sync_in[3];
	assign cur_warn     = sync_in[4];
	assign cur_trip     = sync_in[5];
	assign rtn_fuse     = sync_in[6];
	assign neg_fuse     = sync_in[7];
	assign supplies_off = sync_in[8];
	assign cmd          = hss_cmd_t'(sync_in[10:9]); // R14

	// Status flags are registered so the isolators never see decode glitches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link.supply_in_range_ok <= 1'b0;
			link.fuses_intact       <= 1'b0;
			link.current_healthy    <= 1'b0;
		end else begin
			link.supply_in_range_ok <= low_ok & ~high_over; // R1
			link.fuses_intact       <= rtn_fuse & neg_fuse; // R4 R5
			link.current_healthy    <= ~cur_warn; // R6
		end
	end

	// Persistence timer; saturates so a long sag stays expired
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			crit_low_cnt_reg <= '0;
		end else if (!crit_low) begin
			crit_low_cnt_reg <= '0;
		end else if (!crit_low_expired) begin
			crit_low_cnt_reg <= crit_low_cnt_reg + 32'h1; // R15
		end
	end
	assign crit_low_expired = (crit_low_cnt_reg >= CRIT_LOW_CYCLES_P); // R2

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_prev_reg <= CMD_NORMAL;
		end else begin
			cmd_prev_reg <= cmd;
		end
	end
	// Retry fires on entry to the code only, so a held code does not cycle forever
	assign retry_req = (cmd == CMD_RETRY) && (cmd_prev_reg != CMD_RETRY); // R10

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			retry_cnt_reg <= '0;
		end else if (state_reg != ST_RETRY_WAIT) begin
			retry_cnt_reg <= '0;
		end else if (!retry_done) begin
			retry_cnt_reg <= retry_cnt_reg + 32'h1; // R15
		end
	end
	assign retry_done = (retry_cnt_reg >= RETRY_DELAY_CYCLES_P); // R10

	// A sagging supply must not be switched onto, even before its timer runs out
	assign start_ok  = ~crit_high & ~cur_trip & ~crit_low & (cmd != CMD_DEACTIVATE);
	assign run_fault = crit_high | cur_trip | crit_low_expired; // R2 R3 R7

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_STEP0: begin
				if (start_ok) begin
					state_next = ST_RAMP; // R13
				end else if (cmd == CMD_DEACTIVATE) begin
					state_next = ST_DEACT;
				end
			end
			ST_RAMP, ST_ON: begin
				if (run_fault) begin
					state_next = ST_TRIPPED; // R2 R3 R7
				end else if (cmd == CMD_DEACTIVATE) begin
					state_next = ST_DEACT; // R9
				end else if (retry_req) begin
					state_next = ST_RETRY_OFF; // R10
				end else if (state_reg == ST_RAMP && pass_switch_level == DRIVE_FULL) begin
					state_next = ST_ON; // R12
				end
				// Codes 00 and 11 leave the switch as it is
				// R8 R11
			end
			ST_TRIPPED: begin
				if (start_ok) begin
					state_next = ST_STEP0;
				end
			end
			ST_DEACT: begin
				if (cmd != CMD_DEACTIVATE) begin
					state_next = ST_STEP0; // R9
				end
			end
			ST_RETRY_OFF: begin
				if (cmd == CMD_DEACTIVATE) begin
					state_next = ST_DEACT;
				end else if (supplies_off) begin
					state_next = ST_RETRY_WAIT; // R10
				end
			end
			ST_RETRY_WAIT: begin
				if (cmd == CMD_DEACTIVATE) begin
					state_next = ST_DEACT;
				end else if (retry_done) begin
					state_next = ST_STEP0; // R10
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_STEP0; // R13
		end else begin
			state_reg <= state_next;
		end
	end

	assign drive_next = (state_next == ST_RAMP) || (state_next == ST_ON);

	// Step period grows with the rate setting: setting 0 is the fastest ramp
	assign step_limit = 16'((32'(ramp_rate_sel) + 32'h1) * RAMP_UNIT_CYCLES - 32'h1); // R12
	assign step_tick  = (step_cnt_reg == step_limit);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			step_cnt_reg <= '0;
		end else if (state_reg != ST_RAMP || step_tick) begin
			step_cnt_reg <= '0;
		end else begin
			step_cnt_reg <= step_cnt_reg + 16'h1;
		end
	end

	// Switch-off acts on the next state so the drive falls in the same edge as the decision
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pass_switch_drive <= 1'b0;
			pass_switch_level <= DRIVE_ZERO;
		end else begin
			pass_switch_drive <= drive_next; // R3 R7 R9
			if (!drive_next) begin
				pass_switch_level <= DRIVE_ZERO;
			end else if (state_reg == ST_RAMP && step_tick && pass_switch_level != DRIVE_FULL) begin
				pass_switch_level <= pass_switch_level + 8'h01; // R12
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_shutdown <= 1'b0;
			retry_active   <= 1'b0;
		end else begin
			fault_shutdown <= (state_next == ST_TRIPPED);
			retry_active   <= (state_next == ST_RETRY_OFF) || (state_next == ST_RETRY_WAIT);
		end
	end
endmodule : hss_device
`default_nettype wire

// File: hss_controller.sv
// Management controller end: a Wishbone classic slave holding the command code and
// showing the synchronised supervisory flags. Assumes a single-master Wishbone bus on clk.
`timescale 1ns/1ps
`default_nettype none
module hss_controller
	import hss_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [hss_pkg::WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output var  logic [31:0]                  wb_dat_o,
	output var  logic                         wb_ack_o,
	hss_link_if.controller                    link
);
	import hss_pkg::*;

	logic [1:0]  cmd_reg;
	logic [2:0]  flags_raw;
	logic [2:0]  flags_sync;
	logic        wb_req;
	logic [31:0] read_word;

	assign flags_raw = {link.fuses_intact, link.current_healthy, link.supply_in_range_ok};

	hss_sync #(
		.W        (3)
	) i_hss_sync (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in (flags_raw),
		.sync_out (flags_sync)
	);

	// The code is driven straight from a flop so the isolators see clean transitions
	assign link.host_command_bit0 = cmd_reg[0]; // R14
	assign link.host_command_bit1 = cmd_reg[1]; // R14

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	// Reset leaves code 00, so the supervisor is never told to act before software speaks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_reg <= CMD_RESET; // R8
		end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CMD_OFS) begin
			cmd_reg <= wb_dat_i[1:0]; // R8 R9 R10 R11
		end
	end

	always_comb begin
		read_word = 32'h0000_0000;
		if (wb_adr_i == REG_CMD_OFS) begin
			read_word[1:0] = cmd_reg;
		end else if (wb_adr_i == REG_STATUS_OFS) begin
			read_word[STATUS_RANGE_BIT]   = flags_sync[0];
			read_word[STATUS_CURRENT_BIT] = flags_sync[1];
			read_word[STATUS_FUSE_BIT]    = flags_sync[2];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req) begin
			wb_dat_o <= read_word;
		end
	end
endmodule : hss_controller
`default_nettype wire

// File: hss_link_assertions.sv
// Checker for the supervisor link and the device pins beside it.
// Assumes one clk domain and the shortened critical-low count of the bench.
`timescale 1ns/1ps
`default_nettype none
module hss_link_assertions #(
	parameter int unsigned CRIT_LOW_CYCLES_P = 20
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic host_command_bit0,
	input wire logic host_command_bit1,
	input wire logic supply_in_range_ok,
	input wire logic fuses_intact,
	input wire logic current_healthy,
	input wire logic volt_low_cmp,
	input wire logic volt_high_cmp,
	input wire logic volt_critical_low_cmp,
	input wire logic volt_critical_high_cmp,
	input wire logic current_warn_cmp,
	input wire logic current_trip_cmp,
	input wire logic return_limb_fuse_sense,
	input wire logic neg_limb_fuse_sense,
	input wire logic pass_switch_drive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [7:0] low_cnt_reg;
	wire logic [1:0] cmd = {host_command_bit1, host_command_bit0};
	// Saturates so a long brown-out cannot wrap back into the window
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt_reg <= 8'h00;
		end else if (!volt_critical_low_cmp) begin
			low_cnt_reg <= 8'h00;
		end else if (low_cnt_reg != 8'hFF) begin
			low_cnt_reg <= low_cnt_reg + 8'h01;
		end
	end
	// Eight stable samples cover the four-flop input path plus the output flop
	property p_range_on;
		(volt_low_cmp && !volt_high_cmp) [*8] |-> supply_in_range_ok;
	endproperty
	a_range_on: assert property (p_range_on) else $error("range flag low");
	property p_range_off;
		(!volt_low_cmp || volt_high_cmp) [*8] |-> !supply_in_range_ok;
	endproperty
	a_range_off: assert property (p_range_off) else $error("range flag high");
	property p_fuse_on;
		(return_limb_fuse_sense && neg_limb_fuse_sense) [*8] |-> fuses_intact;
	endproperty
	a_fuse_on: assert property (p_fuse_on) else $error("fuse flag low");
	property p_fuse_off;
		(!return_limb_fuse_sense || !neg_limb_fuse_sense) [*8] |-> !fuses_intact;
	endproperty
	a_fuse_off: assert property (p_fuse_off) else $error("fuse flag high");
	property p_cur;
		current_warn_cmp [*8] |-> !current_healthy;
	endproperty
	a_cur: assert property (p_cur) else $error("current flag high");
	property p_cur_ok;
		!current_warn_cmp [*8] |-> current_healthy;
	endproperty
	a_cur_ok: assert property (p_cur_ok) else $error("current flag low");
	property p_crit_high;
		volt_critical_high_cmp [*8] |-> !pass_switch_drive;
	endproperty
	a_crit_high: assert property (p_crit_high) else $error("switch on at high");
	property p_trip;
		current_trip_cmp [*8] |-> !pass_switch_drive;
	endproperty
	a_trip: assert property (p_trip) else $error("switch on at trip");
	property p_crit_low;
		low_cnt_reg == CRIT_LOW_CYCLES_P + 8 |-> !pass_switch_drive;
	endproperty
	a_crit_low: assert property (p_crit_low) else $error("switch on at low");
	property p_deact;
		(cmd == 2'h1) [*8] |-> !pass_switch_drive;
	endproperty
	a_deact: assert property (p_deact) else $error("switch on at deactivate");
	c_retry: cover property (cmd == 2'h2 ##8 !pass_switch_drive);
	c_deact: cover property (cmd == 2'h1 ##8 !pass_switch_drive);
	c_trip: cover property (current_trip_cmp ##8 !pass_switch_drive);
endmodule : hss_link_assertions
`default_nettype wire

// File: hot_swap_supervisor_tb.sv
// Bench joining both supervisor ends through the link, driven over Wishbone.
// Assumes shortened timer counts; all inputs change by NBA at rising edges.
`timescale 1ns/1ps
`default_nettype none
module hot_swap_supervisor_tb;
	import hss_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic volt_low_cmp = 1'b1, volt_high_cmp = 1'b0, volt_critical_low_cmp = 1'b0;
	logic volt_critical_high_cmp = 1'b0, current_warn_cmp = 1'b0, current_trip_cmp = 1'b0;
	logic return_limb_fuse_sense = 1'b1, neg_limb_fuse_sense = 1'b1, board_supplies_off = 1'b0;
	logic [4:0] ramp_rate_sel = 5'h00;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic wb_ack_o, pass_switch_drive, fault_shutdown, retry_active;
	logic [7:0] pass_switch_level;
	int num_errors = 0;
	int comparisons = 0;
	// {low, high, warn, return fuse, neg fuse, expected status[2:0]}
	logic [7:0] rows [6] = '{8'h9F, 8'h1E, 8'hDE, 8'hBD, 8'h8B, 8'h93};
	hss_link_if link ();
	hss_device #(.CRIT_LOW_CYCLES_P(20), .RETRY_DELAY_CYCLES_P(50)) i_hss_device (
		.clk, .arst_n, .link(link), .volt_low_cmp, .volt_high_cmp, .volt_critical_low_cmp,
		.volt_critical_high_cmp, .current_warn_cmp, .current_trip_cmp, .return_limb_fuse_sense,
		.neg_limb_fuse_sense, .board_supplies_off, .ramp_rate_sel, .pass_switch_drive,
		.pass_switch_level, .fault_shutdown, .retry_active);
	hss_controller i_hss_controller (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link(link));
	hss_link_assertions #(.CRIT_LOW_CYCLES_P(20)) i_hss_link_assertions (.clk, .arst_n,
		.host_command_bit0(link.host_command_bit0), .host_command_bit1(link.host_command_bit1),
		.supply_in_range_ok(link.supply_in_range_ok), .fuses_intact(link.fuses_intact),
		.current_healthy(link.current_healthy), .volt_low_cmp, .volt_high_cmp,
		.volt_critical_low_cmp, .volt_critical_high_cmp, .current_warn_cmp, .current_trip_cmp,
		.return_limb_fuse_sense, .neg_limb_fuse_sense, .pass_switch_drive);
	always #12.5 clk = ~clk;
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	// Ends 1 ns after an edge so flop updates have landed
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= s;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk);
		while (wb_ack_o !== 1'b1) @(posedge clk);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	initial begin
		#(10000 * 25);
		num_errors++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			{volt_low_cmp, volt_high_cmp, current_warn_cmp, return_limb_fuse_sense,
				neg_limb_fuse_sense} <= rows[i][7:3];
			wt(16);
			wb(1'b0, REG_STATUS_OFS, 32'h0);
			chk_word(q, {29'h0, rows[i][2:0]});
		end
		$display("test status table done");
		@(posedge clk);
		neg_limb_fuse_sense <= 1'b1;
		arst_n <= 1'b0;
		wt(2);
		chk_bit(pass_switch_drive, 1'b0);
		@(posedge clk);
		arst_n <= 1'b1;
		wt(10);
		chk_bit(pass_switch_drive, 1'b1);
		chk_bit(pass_switch_level === DRIVE_FULL, 1'b0);
		wt(1100);
		chk_word({24'h0, pass_switch_level}, {24'h0, DRIVE_FULL});
		$display("test power-up ramp done");
		@(posedge clk);
		volt_critical_high_cmp <= 1'b1;
		wt(8);
		chk_bit(pass_switch_drive, 1'b0);
		chk_bit(fault_shutdown, 1'b1);
		@(posedge clk);
		volt_critical_high_cmp <= 1'b0;
		current_trip_cmp <= 1'b1;
		wt(8);
		chk_bit(pass_switch_drive, 1'b0);
		@(posedge clk);
		current_trip_cmp <= 1'b0;
		wt(10);
		chk_bit(pass_switch_drive, 1'b1);
		chk_bit(fault_shutdown, 1'b0);
		@(posedge clk);
		volt_critical_low_cmp <= 1'b1;
		wt(12);
		chk_bit(pass_switch_drive, 1'b1);
		wt(20);
		chk_bit(pass_switch_drive, 1'b0);
		chk_bit(fault_shutdown, 1'b1);
		@(posedge clk);
		volt_critical_low_cmp <= 1'b0;
		wt(10);
		$display("test faults done");
		wb(1'b1, REG_CMD_OFS, 32'h1);
		wt(8);
		chk_bit(pass_switch_drive, 1'b0);
		wb(1'b0, REG_CMD_OFS, 32'h0);
		chk_word(q, 32'h1);
		wb(1'b1, REG_CMD_OFS, 32'h3);
		wt(10);
		chk_bit(pass_switch_drive, 1'b1);
		wb(1'b1, REG_CMD_OFS, 32'h0);
		wt(10);
		chk_bit(pass_switch_drive, 1'b1);
		$display("test commands done");
		@(posedge clk);
		ramp_rate_sel <= 5'h01;
		wb(1'b1, REG_CMD_OFS, 32'h2);
		wt(8);
		chk_bit(pass_switch_drive, 1'b0);
		chk_bit(retry_active, 1'b1);
		wt(60);
		chk_bit(pass_switch_drive, 1'b0);
		@(posedge clk);
		board_supplies_off <= 1'b1;
		wt(30);
		chk_bit(pass_switch_drive, 1'b0);
		wt(40);
		chk_bit(pass_switch_drive, 1'b1);
		chk_bit(retry_active, 1'b0);
		wt(1100);
		chk_bit(pass_switch_level === DRIVE_FULL, 1'b0);
		wt(1100);
		chk_word({24'h0, pass_switch_level}, {24'h0, DRIVE_FULL});
		$display("test retry done");
		wb(1'b1, REG_STATUS_OFS, 32'h0);
		wb(1'b0, 4'h8, 32'h0);
		chk_word(q, 32'h0);
		wb(1'b0, REG_STATUS_OFS, 32'h0);
		chk_word(q, 32'h7);
		// A write without its low byte lane must leave the retry code in place
		wb(1'b1, REG_CMD_OFS, 32'h1, 4'h0);
		wb(1'b0, REG_CMD_OFS, 32'h0);
		chk_word(q, 32'h2);
		$display("test bus refusals done");
		summarize();
	end
endmodule : hot_swap_supervisor_tb
`default_nettype wire
